// ==== src/sta_pkg.sv ====
package sta_pkg;
    // Configuration limits
    localparam int CH_W_MAX = 8;
    localparam int MAX_CH_LIMIT = 255;
    localparam int ERR_W_MAX = 31;
    localparam int LAT_MIN_REG_OUT = 1;
    localparam int BUF_SPARE = 2;

    // Plain defaults for the common payload settings
    localparam int DEF_SYM_BITS = 8;
    localparam int DEF_SYMS = 4;
    localparam int DEF_CH_W = 0;
    localparam int DEF_MAX_CH = 0;
    localparam int DEF_ERR_W = 0;
    localparam int DEF_IN_RL = 1;
    localparam int DEF_OUT_RL = 2;

    // Register port
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 32;
    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] ADDR_MASK = 4'h4;
    localparam logic [REG_ADDR_W-1:0] ADDR_LEVEL = 4'h8;

    // Event bits, same layout in status and mask
    localparam int EVT_W = 2;
    localparam int EVT_LOST = 0;
    localparam int EVT_UNDER = 1;
    localparam logic [EVT_W-1:0] STATUS_RST = 2'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 2'h0;

    // A zero-width field still occupies one port bit, held at zero
    function automatic int pos1(input int w);
        return (w > 0) ? w : 1;
    endfunction

    function automatic int empty_bits(input int syms);
        return (syms > 1) ? $clog2(syms) : 1;
    endfunction
endpackage

// ==== src/sta_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Link between the adapter output and the sink end
interface sta_link_if #(
    parameter int DATA_W = 32,
    parameter int CH_P = 1,
    parameter int EMPTY_P = 2,
    parameter int ERR_P = 1
);
    logic valid;
    logic ready;
    logic [DATA_W-1:0] data;
    logic [CH_P-1:0] channel;
    logic sop;
    logic eop;
    logic [EMPTY_P-1:0] empty;
    logic [ERR_P-1:0] error;

    modport src (output valid, data, channel, sop, eop, empty, error, input ready);
    modport snk (input valid, data, channel, sop, eop, empty, error, output ready);
endinterface
`default_nettype wire

// ==== src/sta_delay.sv ====
`timescale 1ns/100ps
`default_nettype none
module sta_delay #(
    parameter int STAGES = 1
) (
    input wire logic clock_in, // System clock
    input wire logic arst_n_in, // Asynchronous reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic d_in, // Level to delay
    output logic [((STAGES > 0) ? STAGES : 1)-1:0] taps_out, // Tap i is d delayed i+1
    output logic q_out // d delayed by STAGES cycles
);
    if (STAGES < 0)
    begin : g_bad
        $error("sta_delay: STAGES must not be negative");
    end
    if (STAGES == 0)
    begin : g_pass
        // No stage wanted: the level goes straight through
        assign taps_out = '0;
        assign q_out = d_in;
    end
    else
    begin : g_shift
        logic [STAGES-1:0] shift_ff;
        // Shift toward the high end once per enabled cycle
        always_ff @(posedge clock_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
                shift_ff <= '0;
            else if (ce_in)
                shift_ff <= (shift_ff << 1) | STAGES'(d_in);
        end
        assign taps_out = shift_ff;
        assign q_out = shift_ff[STAGES-1];
    end
endmodule
`default_nettype wire

// ==== src/sta_adapter.sv ====
`timescale 1ns/100ps
`default_nettype none
module sta_adapter
    import sta_pkg::*;
#(
    parameter bit IN_READY_EN = 1'b1,
    parameter int IN_RL = DEF_IN_RL,
    parameter bit IN_VALID_EN = 1'b1,
    parameter bit OUT_READY_EN = 1'b1,
    parameter int OUT_RL = DEF_OUT_RL,
    parameter bit OUT_VALID_EN = 1'b1,
    parameter int CH_W = DEF_CH_W,
    parameter int MAX_CH = DEF_MAX_CH,
    parameter int SYM_BITS = DEF_SYM_BITS,
    parameter int SYMS = DEF_SYMS,
    parameter bit PKT_EN = 1'b1,
    parameter bit EMPTY_EN = 1'b1,
    parameter int ERR_W = DEF_ERR_W,
    parameter int BUF_D = IN_RL + ((IN_RL > OUT_RL) ? (IN_RL - OUT_RL) : 0) + BUF_SPARE
) (
    input wire logic clock_in, // System clock
    input wire logic arst_n_in, // Asynchronous reset, active low
    input wire logic ce_in, // Clock enable, freezes all state when low
    input wire logic in_valid_in, // Source beat valid
    input wire logic [SYM_BITS*SYMS-1:0] in_data_in, // Source data
    input wire logic [pos1(CH_W)-1:0] in_channel_in, // Source channel
    input wire logic in_sop_in, // Source first beat of packet
    input wire logic in_eop_in, // Source last beat of packet
    input wire logic [empty_bits(SYMS)-1:0] in_empty_in, // Source empty symbols
    input wire logic [pos1(ERR_W)-1:0] in_error_in, // Source error bits
    output logic in_ready_out, // Ready toward the source
    sta_link_if.src link, // Toward the sink end
    input wire logic [REG_ADDR_W-1:0] reg_addr_in, // Register address
    input wire logic [REG_DATA_W-1:0] reg_wdata_in, // Register write data
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    output logic [REG_DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
    output logic irq_out // High while an unmasked event is pending
);
    localparam int DATA_W = SYM_BITS * SYMS;
    localparam int CH_P = pos1(CH_W);
    localparam int EMP_P = empty_bits(SYMS);
    localparam int ERR_P = pos1(ERR_W);
    localparam int PAY_W = DATA_W + CH_P + 2 + EMP_P + ERR_P;
    localparam int PTR_W = (BUF_D > 1) ? $clog2(BUF_D) : 1;
    localparam int CNT_W = $clog2(BUF_D + 1);
    localparam int IN_TAPS = (IN_RL > 0) ? IN_RL : 1;
    localparam int OUT_STG = (OUT_READY_EN && OUT_RL > 0) ? (OUT_RL - 1) : 0;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_D - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_D);

    // Refuse settings the logic cannot serve
    if (CH_W < 0 || CH_W > CH_W_MAX)
    begin : g_chk_ch
        $error("sta_adapter: CH_W out of range");
    end
    if (MAX_CH < 0 || MAX_CH > MAX_CH_LIMIT)
    begin : g_chk_max
        $error("sta_adapter: MAX_CH out of range");
    end
    if (ERR_W < 0 || ERR_W > ERR_W_MAX)
    begin : g_chk_err
        $error("sta_adapter: ERR_W out of range");
    end
    if (SYM_BITS < 1 || SYMS < 1)
    begin : g_chk_sym
        $error("sta_adapter: symbol settings must be positive");
    end
    if (IN_RL < 0 || (OUT_READY_EN && OUT_RL < LAT_MIN_REG_OUT))
    begin : g_chk_rl
        $error("sta_adapter: ready latency not supported");
    end
    if (BUF_D < IN_RL + BUF_SPARE)
    begin : g_chk_buf
        $error("sta_adapter: BUF_D too small for input latency");
    end
    if ($bits(link.data) != DATA_W || $bits(link.channel) != CH_P ||
        $bits(link.empty) != EMP_P || $bits(link.error) != ERR_P)
    begin : g_chk_link
        $error("sta_adapter: link widths differ from payload");
    end

    logic in_ready_ff;
    logic [IN_TAPS-1:0] in_taps;
    logic in_win;
    logic out_load;
    logic [PAY_W-1:0] mem_ff [BUF_D];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] count_ff;
    logic out_valid_ff;
    logic [PAY_W-1:0] out_pay_ff;
    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [REG_DATA_W-1:0] rdata_ff;
    logic irq_ff;
    logic [PAY_W-1:0] pay_in;
    logic [CH_P-1:0] ch_f;
    logic [EMP_P-1:0] emp_f;
    logic [ERR_P-1:0] err_f;
    logic sop_f;
    logic eop_f;
    logic arrive;
    logic full;
    logic pop;
    logic push;
    logic [EVT_W-1:0] events;
    logic [CNT_W:0] pending;
    logic nxt_in_ready;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    // Input beat window: a beat may arrive IN_RL cycles after ready
    sta_delay #(.STAGES(IN_RL)) u_in_win (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .d_in(in_ready_ff),
        .taps_out(in_taps),
        .q_out(in_win)
    );

    // Sink ready pipelined so the output register lands on its window
    sta_delay #(.STAGES(OUT_STG)) u_out_win (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .d_in(link.ready),
        .taps_out(),
        .q_out(out_load)
    );

    // Gate off fields that the configuration leaves out
    assign ch_f = (CH_W > 0) ? in_channel_in : '0;
    assign sop_f = PKT_EN ? in_sop_in : 1'b0;
    assign eop_f = PKT_EN ? in_eop_in : 1'b0;
    assign emp_f = (PKT_EN && EMPTY_EN) ? in_empty_in : '0;
    assign err_f = (ERR_W > 0) ? in_error_in : '0;
    assign pay_in = {err_f, emp_f, eop_f, sop_f, ch_f, in_data_in};

    // Beat arrival; a source without valid sends a beat every window
    assign arrive = (IN_READY_EN ? in_win : 1'b1) & (IN_VALID_EN ? in_valid_in : 1'b1);
    assign full = (count_ff == CNT_FULL);
    assign pop = (OUT_READY_EN ? out_load : 1'b1) && (count_ff != '0);
    assign push = arrive && (!full || pop);
    // A full buffer cannot refuse a source that ignores ready
    assign events[EVT_LOST] = arrive && full && !pop;
    assign events[EVT_UNDER] = !OUT_VALID_EN && OUT_READY_EN && out_load && (count_ff == '0);

    // Beats still owed by the source: ready cycles in flight
    always_comb
    begin
        pending = (CNT_W + 1)'(in_ready_ff);
        if (IN_RL > 0)
        begin
            for (int i = 0; i < IN_TAPS; i++)
            begin
                pending = pending + (CNT_W + 1)'(in_taps[i]);
            end
        end
        // Conservative: ignores this cycle's pop, costs a little throughput
        nxt_in_ready = ((CNT_W + 1)'(count_ff) + pending) < (CNT_W + 1)'(BUF_D);
        if (!OUT_READY_EN || !IN_READY_EN)
            nxt_in_ready = 1'b1;
    end

    // Ready toward the source
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            in_ready_ff <= 1'b0;
        else if (ce_in)
            in_ready_ff <= nxt_in_ready;
    end

    // Buffer storage; no reset needed on the data words
    always_ff @(posedge clock_in)
    begin
        if (ce_in && push)
            mem_ff[wr_ptr_ff] <= pay_in;
    end

    // Buffer pointers and fill level
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else if (ce_in)
        begin
            if (push)
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop)
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end

    // Output register; a sink without valid sees valid held high
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            out_valid_ff <= 1'b0;
            out_pay_ff <= '0;
        end
        else if (ce_in)
        begin
            out_valid_ff <= OUT_VALID_EN ? pop : 1'b1;
            if (pop)
                out_pay_ff <= mem_ff[rd_ptr_ff];
        end
    end

    // Payload leaves in the same field order it came in
    assign {link.error, link.empty, link.eop, link.sop, link.channel, link.data} = out_pay_ff;
    assign link.valid = out_valid_ff;
    assign in_ready_out = in_ready_ff;

    // Sticky events; a new event wins over a clear in the same cycle
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            status_ff <= STATUS_RST;
        else if (ce_in)
        begin
            if (reg_wr_in && reg_addr_in == ADDR_STATUS)
                status_ff <= (status_ff & ~reg_wdata_in[EVT_W-1:0]) | events;
            else
                status_ff <= status_ff | events;
        end
    end

    // Mask register
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            mask_ff <= MASK_RST;
        else if (ce_in && reg_wr_in && reg_addr_in == ADDR_MASK)
            mask_ff <= reg_wdata_in[EVT_W-1:0];
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_ff <= '0;
        else if (ce_in)
        begin
            rdata_ff <= '0;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    ADDR_STATUS: rdata_ff <= REG_DATA_W'(status_ff);
                    ADDR_MASK: rdata_ff <= REG_DATA_W'(mask_ff);
                    ADDR_LEVEL: rdata_ff <= REG_DATA_W'(count_ff);
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end

    // Interrupt follows the status one cycle late
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            irq_ff <= 1'b0;
        else if (ce_in)
            irq_ff <= |(status_ff & mask_ff);
    end

    assign reg_rdata_out = rdata_ff;
    assign irq_out = irq_ff;
endmodule
`default_nettype wire

// ==== src/sta_sink_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module sta_sink_end
    import sta_pkg::*;
#(
    parameter bit OUT_READY_EN = 1'b1,
    parameter int OUT_RL = DEF_OUT_RL,
    parameter bit OUT_VALID_EN = 1'b1,
    parameter int CH_W = DEF_CH_W,
    parameter int SYM_BITS = DEF_SYM_BITS,
    parameter int SYMS = DEF_SYMS,
    parameter bit PKT_EN = 1'b1,
    parameter int ERR_W = DEF_ERR_W
) (
    input wire logic clock_in, // System clock
    input wire logic arst_n_in, // Asynchronous reset, active low
    input wire logic ce_in, // Clock enable, freezes all state when low
    sta_link_if.snk link, // From the adapter
    input wire logic user_ready_in, // Sink core can take data
    output logic user_valid_out, // Beat taken, one cycle
    output logic [SYM_BITS*SYMS-1:0] user_data_out, // Beat data
    output logic [pos1(CH_W)-1:0] user_channel_out, // Beat channel
    output logic user_sop_out, // First beat of packet
    output logic user_eop_out, // Last beat of packet
    output logic [empty_bits(SYMS)-1:0] user_empty_out, // Empty symbols on last beat
    output logic [pos1(ERR_W)-1:0] user_error_out // Error bits, same meaning as source
);
    localparam int STG = OUT_READY_EN ? OUT_RL : 0;

    if (OUT_RL < 0 || $bits(link.data) != SYM_BITS * SYMS)
    begin : g_chk
        $error("sta_sink_end: settings differ from link");
    end

    logic ready_ff;
    logic win;
    logic take;
    logic valid_ff;
    logic [SYM_BITS*SYMS-1:0] data_ff;
    logic [pos1(CH_W)-1:0] ch_ff;
    logic sop_ff;
    logic eop_ff;
    logic [empty_bits(SYMS)-1:0] empty_ff;
    logic [pos1(ERR_W)-1:0] err_ff;

    // Without backpressure the sink simply always reads as ready
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            ready_ff <= 1'b0;
        else if (ce_in)
            ready_ff <= OUT_READY_EN ? user_ready_in : 1'b1;
    end

    // Data may be taken only OUT_RL cycles after ready
    sta_delay #(.STAGES(STG)) u_win (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .d_in(ready_ff),
        .taps_out(),
        .q_out(win)
    );

    assign take = (OUT_READY_EN ? win : 1'b1) && (OUT_VALID_EN ? link.valid : 1'b1);

    // Capture a beat; empty is only meaningful on a last beat
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            valid_ff <= 1'b0;
            data_ff <= '0;
            ch_ff <= '0;
            sop_ff <= 1'b0;
            eop_ff <= 1'b0;
            empty_ff <= '0;
            err_ff <= '0;
        end
        else if (ce_in)
        begin
            valid_ff <= take;
            if (take)
            begin
                data_ff <= link.data;
                ch_ff <= link.channel;
                sop_ff <= PKT_EN & link.sop;
                eop_ff <= PKT_EN & link.eop;
                empty_ff <= (PKT_EN && link.eop) ? link.empty : '0;
                err_ff <= link.error;
            end
        end
    end

    assign link.ready = ready_ff;
    assign user_valid_out = valid_ff;
    assign user_data_out = data_ff;
    assign user_channel_out = ch_ff;
    assign user_sop_out = sop_ff;
    assign user_eop_out = eop_ff;
    assign user_empty_out = empty_ff;
    assign user_error_out = err_ff;
endmodule
`default_nettype wire

// ==== sim/sta_link_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module sta_link_chk #(
    parameter int DATA_W = 32,
    parameter int CH_P = 1,
    parameter int EMPTY_P = 2,
    parameter int ERR_P = 1,
    parameter int OUT_RL = 2
) (
    input wire logic clock_in, // System clock
    input wire logic arst_n_in, // Asynchronous reset, active low
    input wire logic valid, // Beat on the link
    input wire logic ready, // Sink end ready
    input wire logic [DATA_W-1:0] data, // Link data
    input wire logic [CH_P-1:0] channel, // Link channel
    input wire logic sop, // First beat of packet
    input wire logic eop, // Last beat of packet
    input wire logic [EMPTY_P-1:0] empty, // Empty symbols
    input wire logic [ERR_P-1:0] error // Error bits
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!arst_n_in);

    // A beat may only use a window granted OUT_RL cycles before
    AST_VALID_IN_WINDOW: assert property (valid |-> $past(ready, OUT_RL))
        else $error("link beat outside a ready window");
    // Once ready drops the link must fall silent after the latency
    AST_SILENT_AFTER_FALL: assert property ($fell(ready) |-> ##2 !valid)
        else $error("link beat after ready fell");
    // Payload only moves with a beat, so the sink never sees a torn word
    AST_DATA_HELD: assert property (!valid |-> $stable(data))
        else $error("link data moved without a beat");
    AST_PKT_HELD: assert property ($changed({sop, eop, empty}) |-> valid)
        else $error("packet markers moved without a beat");
    // No channel field configured: the spare port bit stays low
    AST_CHANNEL_ZERO: assert property (!(|channel))
        else $error("channel bit set with no channels");
    AST_ERROR_ZERO: assert property (!(|error))
        else $error("error bit set with no error field");
    // The source only marks empty symbols on the last beat
    AST_EMPTY_ON_EOP: assert property (valid && !eop |-> !(|empty))
        else $error("empty count on a middle beat");
    AST_IDLE_AT_START: assert property ($rose(arst_n_in) |-> !valid ##1 !valid)
        else $error("beat right after reset");
endmodule
`default_nettype wire

// ==== sim/sta_adapter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module sta_adapter_tb
    import sta_pkg::*;
;
    localparam int DW = DEF_SYM_BITS * DEF_SYMS;
    localparam int EW = empty_bits(DEF_SYMS);
    localparam int LEVEL_FULL = DEF_IN_RL + BUF_SPARE;
    localparam int CP = pos1(DEF_CH_W);
    localparam int RP = pos1(DEF_ERR_W);
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic in_valid_in = 1'b0;
    logic [DW-1:0] in_data_in = 32'h0;
    logic in_sop_in = 1'b0;
    logic in_eop_in = 1'b0;
    logic [EW-1:0] in_empty_in = 2'h0;
    logic user_ready_in = 1'b1;
    logic far_ready = 1'b1;
    logic [REG_ADDR_W-1:0] reg_addr_in = 4'h0;
    logic [REG_DATA_W-1:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic ce_in = 1'b1;
    logic [0:0] in_channel_in = 1'h0;
    logic [0:0] in_error_in = 1'h0;
    logic in_ready_out, in2_ready, irq_out, irq2, user_valid_out, user_sop_out, user_eop_out;
    logic [REG_DATA_W-1:0] reg_rdata_out, rdata2;
    logic [DW-1:0] user_data_out;
    logic [0:0] user_channel_out, user_error_out;
    logic [EW-1:0] user_empty_out;
    logic [DW+EW+1:0] rx_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int far_beats = 0;

    sta_link_if #(.DATA_W(DW), .CH_P(CP), .EMPTY_P(EW), .ERR_P(RP)) link ();
    sta_link_if #(.DATA_W(DW), .CH_P(CP), .EMPTY_P(EW), .ERR_P(RP)) link2 ();

    always #12.5 clock_in = ~clock_in;
    // Second adapter has a source without ready, so it can lose beats
    assign link2.ready = far_ready;

    sta_adapter u_sta_adapter (.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
        .in_valid_in(in_valid_in), .in_data_in(in_data_in), .in_channel_in(in_channel_in),
        .in_sop_in(in_sop_in), .in_eop_in(in_eop_in), .in_empty_in(in_empty_in),
        .in_error_in(in_error_in), .in_ready_out(in_ready_out), .link(link),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
    sta_adapter #(.IN_READY_EN(1'b0)) u_sta_adapter_2 (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .ce_in(ce_in), .in_valid_in(in_valid_in), .in_data_in(in_data_in),
        .in_channel_in(in_channel_in), .in_sop_in(in_sop_in), .in_eop_in(in_eop_in),
        .in_empty_in(in_empty_in), .in_error_in(in_error_in), .in_ready_out(in2_ready),
        .link(link2), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata2), .irq_out(irq2));
    sta_sink_end u_sta_sink_end (.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
        .link(link), .user_ready_in(user_ready_in), .user_valid_out(user_valid_out),
        .user_data_out(user_data_out), .user_channel_out(user_channel_out),
        .user_sop_out(user_sop_out), .user_eop_out(user_eop_out),
        .user_empty_out(user_empty_out), .user_error_out(user_error_out));
    sta_link_chk #(.DATA_W(DW), .CH_P(CP), .EMPTY_P(EW), .ERR_P(RP), .OUT_RL(DEF_OUT_RL)) chk (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .valid(link.valid), .ready(link.ready),
        .data(link.data), .channel(link.channel), .sop(link.sop), .eop(link.eop),
        .empty(link.empty), .error(link.error));

    task automatic final_report();
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Collect delivered beats; the watchdog cuts a hang short
    always @(posedge clock_in)
    begin
        if (user_valid_out)
        begin
            rx_q.push_back({user_sop_out, user_eop_out, user_empty_out, user_data_out});
            check(user_channel_out === 1'h0 && user_error_out === 1'h0, "side field");
        end
        if (link2.valid)
            far_beats++;
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask

    // Both adapters share the register strobes; each answers on its own port
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d1, output logic [31:0] d2);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(posedge clock_in);
        d1 = reg_rdata_out;
        d2 = rdata2;
    endtask

    task automatic expect_reg(input logic [3:0] a, input logic [31:0] e1, input logic [31:0] e2,
                              input string msg);
        logic [31:0] d1;
        logic [31:0] d2;
        reg_read(a, d1, d2);
        check(d1 === e1 && d2 === e2, msg);
    endtask

    task automatic t_regs();
        expect_reg(ADDR_STATUS, 32'h0, 32'h0, "status reset");
        expect_reg(ADDR_MASK, 32'h0, 32'h0, "mask reset");
        expect_reg(4'hC, 32'h0, 32'h0, "unmapped read");
        // A frozen block must ignore a write strobe
        @(posedge clock_in);
        ce_in <= 1'b0;
        reg_write(ADDR_MASK, 32'h3);
        @(posedge clock_in);
        ce_in <= 1'b1;
        expect_reg(ADDR_MASK, 32'h0, 32'h0, "write while frozen");
    endtask

    // A packet of n beats; the source obeys ready, the sink may stall
    task automatic t_stream(input int n, input bit stall);
        int i;
        int k;
        bit held;
        i = 0;
        held = 1'b0;
        rx_q.delete();
        for (k = 0; k < 300 && i < n; k++)
        begin
            @(posedge clock_in);
            user_ready_in <= !stall || (k % 5 < 2);
            held = held || !in_ready_out;
            in_valid_in <= in_ready_out;
            in_data_in <= 32'hC0DE0000 + i;
            in_sop_in <= (i == 0);
            in_eop_in <= (i == n - 1);
            in_empty_in <= (i == n - 1) ? 2'h2 : 2'h0;
            // Unconfigured side fields toggle; the far end must still see zero
            in_channel_in <= 1'(i);
            in_error_in <= 1'(i + 1);
            if (in_ready_out)
                i++;
        end
        @(posedge clock_in);
        in_valid_in <= 1'b0;
        user_ready_in <= 1'b1;
        for (k = 0; k < 60 && rx_q.size() < n; k++)
            @(posedge clock_in);
        check(rx_q.size() == n, "beat count");
        for (k = 0; k < n && k < rx_q.size(); k++)
            check(rx_q[k] === {k == 0, k == n - 1, (k == n - 1) ? 2'h2 : 2'h0,
                               32'hC0DE0000 + k}, "payload changed");
        // The credit check may also throttle the source under a free-running sink, so only a stall is judged
        if (stall)
            check(held === 1'b1, "ready did not follow the sink");
        expect_reg(ADDR_STATUS, 32'h0, 32'h0, "loss without overflow");
    endtask

    // Source ignores backpressure while both sinks stall
    task automatic t_flood();
        int k;
        int base;
        logic [31:0] d1;
        logic [31:0] d2;
        @(posedge clock_in);
        user_ready_in <= 1'b0;
        far_ready <= 1'b0;
        repeat (4) @(posedge clock_in);
        in_valid_in <= 1'b1;
        repeat (12) @(posedge clock_in);
        in_valid_in <= 1'b0;
        expect_reg(ADDR_STATUS, 32'h0, 32'h1, "lost beat flag");
        check(irq_out === 1'b0 && irq2 === 1'b0, "masked irq");
        reg_write(ADDR_LEVEL, 32'h0);
        reg_read(ADDR_LEVEL, d1, d2);
        check(d2 === 32'(LEVEL_FULL), "fill level");
        check(d1 === 32'(LEVEL_FULL), "credit fill level");
        reg_write(ADDR_MASK, 32'h1);
        expect_reg(ADDR_MASK, 32'h1, 32'h1, "mask readback");
        check(irq_out === 1'b0 && irq2 === 1'b1, "irq follows mask");
        reg_write(ADDR_STATUS, 32'h1);
        expect_reg(ADDR_STATUS, 32'h0, 32'h0, "status clear");
        check(irq2 === 1'b0, "irq after clear");
        base = far_beats;
        user_ready_in <= 1'b1;
        far_ready <= 1'b1;
        for (k = 0; k < 40 && far_beats - base < LEVEL_FULL; k++)
            @(posedge clock_in);
        repeat (4) @(posedge clock_in);
        check(far_beats - base == LEVEL_FULL, "drained beats");
        check(in2_ready === 1'b1, "ready toward a source without ready");
    endtask

    initial
    begin
        repeat (8) @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_regs();
        t_stream(8, 1'b0);
        t_stream(12, 1'b1);
        t_flood();
        final_report();
    end
endmodule
`default_nettype wire
